// ===== verilog/asp_defs.svh
// Purpose: constants of the addressed serial command port
// Assumes: 25 MHz system clock, APB byte addresses
// Notes: field layouts live in asp_pkg as packed structs
`ifndef ASP_DEFS_SVH
`define ASP_DEFS_SVH
`define ASP_CLK_HZ 25000000
`define ASP_OFS_CTRL 8'h00
`define ASP_OFS_STAT 8'h04
`define ASP_OFS_RXD 8'h08
`define ASP_OFS_TXD 8'h0C
`define ASP_CTRL_RST 21'h000014
`define ASP_BAUD_0 300
`define ASP_BAUD_1 1200
`define ASP_BAUD_2 2400
`define ASP_BAUD_3 4800
`define ASP_BAUD_4 9600
`define ASP_BAUD_5 19200
`define ASP_BAUD_6 38400
`define ASP_BAUD_7 57600
`define ASP_BAUD_8 115200
`define ASP_SEL_9600 4'h4
`define ASP_CH_HASH 8'h23
`define ASP_CH_CR 8'h0D
`define ASP_CH_LF 8'h0A
`define ASP_CH_ZERO 8'h30
`define ASP_DEC 8'h0A
`define ASP_HUND 8'h64
`define ASP_PFX_LEN 3'h4
`define ASP_ADDR_DIGITS 2'h3
`endif

// ===== verilog/asp_pkg.sv
// Purpose: types of the addressed serial command port
// Assumes: included constants from asp_defs.svh
// Notes: none
package asp_pkg;
	typedef enum logic [1:0] {ASP_PAR_NONE = 2'h0, ASP_PAR_EVEN = 2'h1, ASP_PAR_ODD = 2'h2} asp_par_e;
	typedef enum logic [1:0] {ASP_TERM_CRLF = 2'h0, ASP_TERM_LF = 2'h1, ASP_TERM_CR = 2'h2} asp_term_e;
	typedef enum logic [3:0] {ASP_R_START = 4'h1, ASP_R_ADDR = 4'h2, ASP_R_BODY = 4'h4,
		ASP_R_SKIP = 4'h8} asp_rxf_e;
	typedef struct packed {
		logic enable;
		logic [7:0] station;
		logic half_duplex;
		logic multidrop;
		asp_term_e term;
		asp_par_e parity;
		logic stop2;
		logic eight;
		logic [3:0] baud;
	} asp_ctrl_s;
	typedef struct packed {
		logic overrun;
		logic frame_err;
		logic parity_err;
		logic cmd_done;
		logic tx_full;
		logic tx_busy;
		logic rx_valid;
	} asp_stat_s;
endpackage

// ===== verilog/asp_top.sv
// Purpose: addressed serial command port, APB slave with shared UART
// Assumes: APB3 master, async line inputs synchronised here
// Notes: one receive and one transmit holding register, no FIFO
//
// Decided for this implementation: the address map and the APB slave port.
`timescale 1ns/1ps
`include "asp_defs.svh"
module asp_top
(
	// clock and reset
	input wire logic CLK_SYS,
	input wire logic RST_N,
	// apb slave
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PWRITE,
	input wire logic [7:0] PADDR,
	input wire logic [31:0] PWDATA,
	output logic [31:0] PRDATA,
	output logic PREADY,
	output logic PSLVERR,
	// point-to-point pins
	input wire logic RXD,
	output logic TXD,
	// multi-drop pins, receive pair and driven pair
	input wire logic RX485,
	output logic TX485,
	output logic TX485_OE_N
);
	asp_pkg::asp_ctrl_s ctrl;
	asp_pkg::asp_stat_s stat;
	asp_pkg::asp_rxf_e rxf;
	logic pready;
	logic rxd_m, rxd_s, r485_m, r485_s, rx_prev;
	logic [16:0] rx_cnt, tx_cnt;
	logic [3:0] rx_idx, tx_idx;
	logic [11:0] rx_sh, tx_frame;
	logic rx_busy, tx_busy, tx_pend, tx_sof, prev_cr;
	logic [7:0] rx_data, tx_hold;
	logic [2:0] tx_pfx;
	logic [1:0] dig;

	function automatic logic [16:0] asp_div(input logic [3:0] sel);
		case (sel)
			4'h0: asp_div = 17'(`ASP_CLK_HZ / `ASP_BAUD_0);
			4'h1: asp_div = 17'(`ASP_CLK_HZ / `ASP_BAUD_1);
			4'h2: asp_div = 17'(`ASP_CLK_HZ / `ASP_BAUD_2);
			4'h3: asp_div = 17'(`ASP_CLK_HZ / `ASP_BAUD_3);
			4'h4: asp_div = 17'(`ASP_CLK_HZ / `ASP_BAUD_4);
			4'h5: asp_div = 17'(`ASP_CLK_HZ / `ASP_BAUD_5);
			4'h6: asp_div = 17'(`ASP_CLK_HZ / `ASP_BAUD_6);
			4'h7: asp_div = 17'(`ASP_CLK_HZ / `ASP_BAUD_7);
			default: asp_div = 17'(`ASP_CLK_HZ / `ASP_BAUD_8);
		endcase
	endfunction

	// k = 0 hundreds, 1 tens, 2 units; always three characters
	function automatic logic [7:0] asp_digit(input logic [7:0] a, input logic [1:0] k);
		case (k)
			2'h0: asp_digit = `ASP_CH_ZERO + a / `ASP_HUND;
			2'h1: asp_digit = `ASP_CH_ZERO + (a / `ASP_DEC) % `ASP_DEC;
			default: asp_digit = `ASP_CH_ZERO + a % `ASP_DEC;
		endcase
	endfunction

	function automatic logic [11:0] asp_frame(input logic [7:0] d, input asp_pkg::asp_ctrl_s c);
		logic [11:0] f;
		f = 12'hFFF;
		f[0] = 1'b0;
		for (int i = 0; i < 8; i++)
			if (i < 7 || c.eight)
				f[i + 1] = d[i];
		if (c.parity != asp_pkg::ASP_PAR_NONE)
			f[c.eight ? 9 : 8] = (^(d & {c.eight, 7'h7F})) ^ (c.parity == asp_pkg::ASP_PAR_ODD);
		asp_frame = f;
	endfunction

	// selection and decoding
	wire [16:0] bit_div = asp_div(ctrl.baud);
	wire has_par = ctrl.parity != asp_pkg::ASP_PAR_NONE;
	wire [3:0] rx_nb = 4'h2 + (ctrl.eight ? 4'h8 : 4'h7) + {3'h0, has_par};
	wire [3:0] tx_nb = rx_nb + {3'h0, ctrl.stop2};
	wire rx_line = ctrl.multidrop ? r485_s : rxd_s;
	wire rx_mute = ctrl.multidrop & ctrl.half_duplex & tx_busy;
	wire rx_start = ctrl.enable & ~rx_busy & ~rx_mute & rx_prev & ~rx_line;
	wire rx_tick = rx_busy & (rx_cnt == 17'h0);
	// >= keeps a frame ending even if the format shrinks mid-character
	wire rx_done = rx_tick & (rx_idx >= rx_nb - 4'h1);
	wire [7:0] rx_ch = {ctrl.eight & rx_sh[8], rx_sh[7:1]};
	wire rx_pbit = ctrl.eight ? rx_sh[9] : rx_sh[8];
	wire rx_perr = has_par & (rx_pbit != ((^rx_ch) ^ (ctrl.parity == asp_pkg::ASP_PAR_ODD)));
	wire rx_ferr = ~rx_line;
	wire is_lf = rx_ch == `ASP_CH_LF;
	wire is_cr = rx_ch == `ASP_CH_CR;
	wire rx_end = (ctrl.term == asp_pkg::ASP_TERM_CR) ? is_cr :
		(ctrl.term == asp_pkg::ASP_TERM_LF) ? is_lf : (is_lf & prev_cr);
	wire rx_ok = rx_done & ~rx_ferr;
	wire addr_hit = rx_ch == asp_digit(ctrl.station, dig);
	wire rx_push = rx_ok & (rxf == asp_pkg::ASP_R_BODY | (rxf == asp_pkg::ASP_R_START &
		~ctrl.multidrop));
	wire cmd_end = rx_ok & rx_end & (rxf == asp_pkg::ASP_R_BODY | (rxf == asp_pkg::ASP_R_START &
		~ctrl.multidrop));
	// prefix goes out ahead of the first body character of each multi-drop response
	wire tx_load = ctrl.enable & ~tx_busy & tx_pend;
	wire tx_pfx_now = ctrl.multidrop & tx_sof & (tx_pfx != `ASP_PFX_LEN);
	wire [7:0] tx_ch = ~tx_pfx_now ? tx_hold : (tx_pfx == 3'h0) ? `ASP_CH_HASH :
		asp_digit(ctrl.station, tx_pfx[1:0] - 2'h1);
	wire tx_last = tx_hold == ((ctrl.term == asp_pkg::ASP_TERM_CR) ? `ASP_CH_CR : `ASP_CH_LF);
	wire tx_tick = tx_busy & (tx_cnt == 17'h0);
	wire acc = PSEL & PENABLE & pready;
	wire wr = acc & PWRITE;
	wire rd_rx = acc & ~PWRITE & (PADDR == `ASP_OFS_RXD);
	wire hit = PADDR == `ASP_OFS_CTRL | PADDR == `ASP_OFS_STAT | PADDR == `ASP_OFS_RXD |
		PADDR == `ASP_OFS_TXD;
	wire [31:0] next_prdata = (PADDR == `ASP_OFS_CTRL) ? {11'h0, ctrl} :
		(PADDR == `ASP_OFS_STAT) ? {25'h0, stat} :
		(PADDR == `ASP_OFS_RXD) ? {24'h0, rx_data} : 32'h0;
	wire stat_w1c = wr & (PADDR == `ASP_OFS_STAT);
	wire ctrl_wr = wr & (PADDR == `ASP_OFS_CTRL);

	// apb: one wait state, answer registered
	always_ff @(posedge CLK_SYS)
	begin
		if (!RST_N)
		begin
			pready <= 1'b0;
			PRDATA <= 32'h0;
			PSLVERR <= 1'b0;
		end
		else
		begin
			pready <= PSEL & PENABLE & ~pready;
			PRDATA <= next_prdata;
			PSLVERR <= PSEL & PENABLE & ~pready & ~hit;
		end
	end
	assign PREADY = pready;

	always_ff @(posedge CLK_SYS)
	begin
		if (!RST_N)
			ctrl <= `ASP_CTRL_RST;
		else if (wr & (PADDR == `ASP_OFS_CTRL))
			ctrl <= PWDATA[20:0];
	end

	// first flops read only by the second
	always_ff @(posedge CLK_SYS)
	begin
		if (!RST_N)
			{rxd_m, rxd_s, r485_m, r485_s, rx_prev} <= 5'h1F;
		else
			{rxd_m, rxd_s, r485_m, r485_s, rx_prev} <= {RXD, rxd_m, RX485, r485_m, rx_line};
	end

	// receiver: sample at mid-bit, first stop bit checked
	always_ff @(posedge CLK_SYS)
	begin
		if (!RST_N)
		begin
			rx_busy <= 1'b0;
			rx_cnt <= 17'h0;
			rx_idx <= 4'h0;
			rx_sh <= 12'h0;
		end
		else if (rx_start)
		begin
			rx_busy <= 1'b1;
			rx_cnt <= {1'b0, bit_div[16:1]};
			rx_idx <= 4'h0;
		end
		else if (rx_tick)
		begin
			rx_sh[rx_idx] <= rx_line;
			rx_idx <= rx_idx + 4'h1;
			rx_cnt <= bit_div - 17'h1;
			rx_busy <= ~rx_done & ~(rx_idx == 4'h0 & rx_line);
		end
		else if (rx_busy)
			rx_cnt <= rx_cnt - 17'h1;
	end

	// command framing and address filter
	always_ff @(posedge CLK_SYS)
	begin
		if (!RST_N)
		begin
			rxf <= asp_pkg::ASP_R_START;
			dig <= 2'h0;
			prev_cr <= 1'b0;
		end
		else if (ctrl_wr)
		begin
			// new setting: stale half-command must not leak into the new mode
			rxf <= asp_pkg::ASP_R_START;
			prev_cr <= 1'b0;
		end
		else if (rx_ok)
		begin
			prev_cr <= is_cr;
			case (rxf)
				asp_pkg::ASP_R_START:
					if (!ctrl.multidrop)
						rxf <= rx_end ? asp_pkg::ASP_R_START : asp_pkg::ASP_R_BODY;
					else if (rx_ch == `ASP_CH_HASH)
					begin
						rxf <= asp_pkg::ASP_R_ADDR;
						dig <= 2'h0;
					end
					else if (!rx_end)
						rxf <= asp_pkg::ASP_R_SKIP;
				asp_pkg::ASP_R_ADDR:
				begin
					dig <= dig + 2'h1;
					if (rx_end)
						rxf <= asp_pkg::ASP_R_START;
					else if (!addr_hit)
						rxf <= asp_pkg::ASP_R_SKIP;
					else if (dig == `ASP_ADDR_DIGITS - 2'h1)
						rxf <= asp_pkg::ASP_R_BODY;
				end
				asp_pkg::ASP_R_BODY:
					if (rx_end)
						rxf <= asp_pkg::ASP_R_START;
				asp_pkg::ASP_R_SKIP:
					if (rx_end)
						rxf <= asp_pkg::ASP_R_START;
				default:
					rxf <= asp_pkg::ASP_R_START;
			endcase
		end
	end

	// status: hardware set wins over software clear
	always_ff @(posedge CLK_SYS)
	begin
		if (!RST_N)
		begin
			stat <= 7'h0;
			rx_data <= 8'h0;
		end
		else
		begin
			stat.rx_valid <= rx_push | (stat.rx_valid & ~rd_rx);
			stat.tx_busy <= tx_busy;
			stat.tx_full <= tx_pend;
			stat.cmd_done <= cmd_end | (stat.cmd_done & ~(stat_w1c & PWDATA[3]));
			stat.parity_err <= (rx_ok & rx_perr) | (stat.parity_err & ~(stat_w1c & PWDATA[4]));
			stat.frame_err <= (rx_done & rx_ferr) | (stat.frame_err & ~(stat_w1c & PWDATA[5]));
			stat.overrun <= (rx_push & stat.rx_valid & ~rd_rx) |
				(stat.overrun & ~(stat_w1c & PWDATA[6]));
			if (rx_push)
				rx_data <= rx_ch;
		end
	end

	// transmitter with automatic address prefix
	always_ff @(posedge CLK_SYS)
	begin
		if (!RST_N)
		begin
			tx_busy <= 1'b0;
			tx_pend <= 1'b0;
			tx_hold <= 8'h0;
			tx_sof <= 1'b1;
			tx_pfx <= 3'h0;
			tx_cnt <= 17'h0;
			tx_idx <= 4'h0;
			tx_frame <= 12'hFFF;
		end
		else
		begin
			if (tx_load)
			begin
				tx_busy <= 1'b1;
				tx_cnt <= bit_div - 17'h1;
				tx_idx <= 4'h0;
				tx_frame <= asp_frame(tx_ch, ctrl);
				tx_pfx <= tx_pfx_now ? tx_pfx + 3'h1 : (tx_last ? 3'h0 : tx_pfx);
				tx_sof <= tx_pfx_now | tx_last;
			end
			else if (tx_tick)
			begin
				tx_cnt <= bit_div - 17'h1;
				tx_idx <= tx_idx + 4'h1;
				tx_frame <= {1'b1, tx_frame[11:1]};
				tx_busy <= tx_idx < tx_nb - 4'h1;
			end
			else if (tx_busy)
				tx_cnt <= tx_cnt - 17'h1;
			if (tx_load & ~tx_pfx_now)
				tx_pend <= 1'b0;
			else if (wr & (PADDR == `ASP_OFS_TXD) & ~tx_pend)
			begin
				tx_pend <= 1'b1;
				tx_hold <= PWDATA[7:0];
			end
			// a new setting starts a fresh response, prefix first
			if (ctrl_wr)
			begin
				tx_sof <= 1'b1;
				tx_pfx <= 3'h0;
			end
		end
	end

	// only the selected mode drives its pins
	always_ff @(posedge CLK_SYS)
	begin
		if (!RST_N)
		begin
			TXD <= 1'b1;
			TX485 <= 1'b1;
			TX485_OE_N <= 1'b1;
		end
		else
		begin
			TXD <= ctrl.multidrop | ~tx_busy | tx_frame[0];
			TX485 <= ~ctrl.multidrop | ~tx_busy | tx_frame[0];
			TX485_OE_N <= ~(ctrl.multidrop & (~ctrl.half_duplex | tx_busy));
		end
	end

	AST_P2P_TX485_QUIET: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
		!ctrl.multidrop ##1 !ctrl.multidrop |-> TX485 && TX485_OE_N)
		else $error("multi-drop driver active in point-to-point mode");
	AST_MD_TXD_QUIET: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
		ctrl.multidrop ##1 ctrl.multidrop |-> TXD)
		else $error("point-to-point line driven in multi-drop mode");
	AST_HALF_DRIVE: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
		$past(ctrl.multidrop && ctrl.half_duplex) && !TX485_OE_N |-> $past(tx_busy))
		else $error("half duplex driver on while idle");
	AST_DIV_9600: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
		ctrl.baud == `ASP_SEL_9600 |-> bit_div == 17'(`ASP_CLK_HZ / `ASP_BAUD_4))
		else $error("wrong divisor for 9600 baud");
	AST_FRAME_LEN: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
		tx_load |=> tx_busy && tx_frame[0] == 1'b0 &&
		tx_nb == 4'h9 + {3'h0, ctrl.eight} + {3'h0, has_par} + {3'h0, ctrl.stop2})
		else $error("frame start or length wrong");
	AST_PREFIX_HASH: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
		tx_load && ctrl.multidrop && tx_sof && tx_pfx == 3'h0 |-> tx_ch == `ASP_CH_HASH)
		else $error("response does not open with hash");
	AST_PREFIX_DIGIT: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
		tx_load && tx_pfx_now && tx_pfx == 3'h1 |->
		tx_ch == `ASP_CH_ZERO + ctrl.station / `ASP_HUND)
		else $error("hundreds digit of address wrong");
	AST_DISCARD: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
		rxf == asp_pkg::ASP_R_SKIP |-> !rx_push && !cmd_end)
		else $error("foreign command character delivered");
	AST_TERM_END: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
		cmd_end |-> rx_end ##1 rxf == asp_pkg::ASP_R_START && stat.cmd_done)
		else $error("command end not on terminator");
	COV_MD_CMD: cover property (@(posedge CLK_SYS) cmd_end && ctrl.multidrop);
	COV_SKIP: cover property (@(posedge CLK_SYS) rxf == asp_pkg::ASP_R_SKIP && rx_ok && rx_end);
	COV_PREFIX: cover property (@(posedge CLK_SYS) tx_load && tx_pfx == 3'h3);
endmodule // asp_top

// ===== verif/asp_host.sv
// Purpose: host controller model on the serial lines of asp_top
// Assumes: bench sets format fields before each character
// Notes: idle line held high, as the line rests at its idle level
`timescale 1ns/1ps
module asp_host
(
	// clock
	input wire logic clk,
	// serial lines
	input wire logic line_in,
	output logic line_out
);
	// floor(25e6 / 115200)
	int bit_t = 217;
	int nb = 8;
	int par = 0;
	int sb = 1;
	logic [7:0] rx_q[$];
	initial line_out = 1'b1;
	task automatic put_bit(input logic b);
		line_out <= b;
		repeat (bit_t) @(posedge clk);
	endtask
	// start, data lsb first, parity, stop bits
	task automatic send_char(input logic [7:0] c);
		logic p;
		p = (par == 2) ^ (^(c & ((nb == 8) ? 8'hFF : 8'h7F)));
		put_bit(1'b0);
		for (int i = 0; i < nb; i++)
			put_bit(c[i]);
		if (par != 0)
			put_bit(p);
		repeat (sb) put_bit(1'b1);
	endtask
	// samples mid-bit, same format as sender
	initial
	begin
		logic [7:0] c;
		forever
		begin
			@(posedge clk);
			if (line_in === 1'b0)
			begin
				c = 8'h00;
				repeat (bit_t / 2) @(posedge clk);
				for (int i = 0; i < nb; i++)
				begin
					repeat (bit_t) @(posedge clk);
					c[i] = line_in;
				end
				repeat (bit_t * (sb + (par != 0))) @(posedge clk);
				rx_q.push_back(c);
			end
		end
	end
endmodule // asp_host

// ===== verif/tb_asp_top.sv
// Purpose: self-checking bench of asp_top
// Assumes: host model asp_host on the serial lines
// Notes: line rate 115200 keeps the run short
`timescale 1ns/1ps
module tb_asp_top;
	logic CLK_SYS, RST_N, PSEL, PENABLE, PWRITE, TXD, RXD, RX485, TX485, TX485_OE_N;
	logic PREADY, PSLVERR, md, hl, er;
	logic [7:0] PADDR;
	logic [31:0] PWDATA, PRDATA, rd;
	int mismatches, checks;
	// slverr, address, read data
	logic [40:0] rows [3] = '{{1'b0, 8'h00, 32'h00000014}, {1'b0, 8'h04, 32'h00000000},
		{1'b1, 8'h10, 32'h00000000}};
	logic [7:0] cmd [6] = '{8'h23, 8'h30, 8'h34, 8'h38, 8'h70, 8'h0A};
	// only the selected mode's receive line carries traffic
	assign RXD = md ? 1'b1 : hl;
	assign RX485 = md ? hl : 1'b1;
	asp_top dut_u (.CLK_SYS(CLK_SYS), .RST_N(RST_N), .PSEL(PSEL), .PENABLE(PENABLE),
		.PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY),
		.PSLVERR(PSLVERR), .RXD(RXD), .TXD(TXD), .RX485(RX485), .TX485(TX485),
		.TX485_OE_N(TX485_OE_N));
	asp_host host_u (.clk(CLK_SYS), .line_in(md ? TX485 : TXD), .line_out(hl));
	initial
	begin
		CLK_SYS = 1'b0;
		forever #20 CLK_SYS = ~CLK_SYS;
	end
	task automatic cmp(input logic [32:0] g, input logic [32:0] e);
		checks++;
		if (g !== e)
		begin
			mismatches++;
			$display("[ERR] t=%0t got %h exp %h", $time, g, e);
		end
	endtask
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		PSEL <= 1'b1;
		PWRITE <= w;
		PADDR <= a;
		PWDATA <= d;
		@(posedge CLK_SYS);
		PENABLE <= 1'b1;
		// no local limit: only the watchdog ends a hung access
		do
			@(posedge CLK_SYS);
		while (PREADY !== 1'b1);
		rd = PRDATA;
		er = PSLVERR;
		PSEL <= 1'b0;
		PENABLE <= 1'b0;
		@(posedge CLK_SYS);
	endtask
	task automatic rchk(input logic [7:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h00000000);
		cmp(rd, e);
	endtask
	task automatic wait_rx(input int n);
		int k;
		k = 0;
		while (host_u.rx_q.size() < n && k < 20000)
		begin
			@(posedge CLK_SYS);
			k++;
		end
	endtask
	task automatic wrap_up;
		$display("checks %0d mismatches %0d", checks, mismatches);
		if (mismatches == 0 && checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	initial
	begin
		repeat (90000) @(posedge CLK_SYS);
		mismatches++;
		wrap_up();
	end
	initial
	begin
		{PSEL, PENABLE, PWRITE, PADDR, PWDATA, md} = '0;
		RST_N = 1'b0;
		mismatches = 0;
		checks = 0;
		repeat (4) @(posedge CLK_SYS);
		RST_N <= 1'b1;
		repeat (3) @(posedge CLK_SYS);
		cmp({TXD, TX485, TX485_OE_N}, 3'h7);
		foreach (rows[i])
		begin
			apb(1'b0, rows[i][39:32], 32'h00000000);
			cmp({er, er ? 32'h00000000 : rd}, {rows[i][40], rows[i][31:0]});
		end
		$display("test reset and table done");
		apb(1'b1, 8'h00, 32'h00100018);
		apb(1'b1, 8'h0C, 32'h00000041);
		wait_rx(1);
		cmp(host_u.rx_q.pop_front(), 8'h41);
		cmp(TX485, 1'b1);
		host_u.send_char(8'h7A);
		rchk(8'h08, 32'h0000007A);
		$display("test point-to-point done");
		apb(1'b1, 8'h00, 32'h00100068);
		host_u.nb = 7;
		host_u.par = 1;
		host_u.sb = 2;
		host_u.send_char(8'h4B);
		rchk(8'h08, 32'h0000004B);
		rchk(8'h04, 32'h00000000);
		apb(1'b1, 8'h0C, 32'h00000071);
		wait_rx(1);
		cmp(host_u.rx_q.pop_front(), 8'h71);
		host_u.nb = 8;
		host_u.par = 0;
		host_u.sb = 1;
		$display("test seven-bit even two-stop done");
		md <= 1'b1;
		apb(1'b1, 8'h00, 32'h0012F518);
		@(posedge CLK_SYS);
		cmp({TXD, TX485_OE_N}, 2'h2);
		// foreign station 048, LF terminated
		foreach (cmd[i])
			host_u.send_char(cmd[i]);
		rchk(8'h04, 32'h00000000);
		cmd[3] = 8'h37;
		apb(1'b1, 8'h0C, 32'h00000070);
		wait_rx(5);
		for (int i = 0; i < 5; i++)
			cmp(host_u.rx_q.pop_front(), cmd[i]);
		for (int i = 0; i < 6; i++)
		begin
			host_u.send_char(cmd[i]);
			if (i >= 4)
				rchk(8'h08, {24'h000000, cmd[i]});
		end
		rchk(8'h04, 32'h00000008);
		apb(1'b1, 8'h00, 32'h0012FD18);
		repeat (2) @(posedge CLK_SYS);
		cmp(TX485_OE_N, 1'b1);
		$display("test multi-drop done");
		// half duplex response; second write while full is dropped
		apb(1'b1, 8'h0C, 32'h0000000A);
		apb(1'b1, 8'h0C, 32'h0000007A);
		wait_rx(1);
		rchk(8'h04, 32'h0000000E);
		cmp(TX485_OE_N, 1'b0);
		wait_rx(5);
		for (int i = 0; i < 4; i++)
			cmp(host_u.rx_q.pop_front(), cmd[i]);
		cmp(host_u.rx_q.pop_front(), cmd[5]);
		repeat (2500) @(posedge CLK_SYS);
		cmp(host_u.rx_q.size(), 0);
		cmp(TX485_OE_N, 1'b1);
		$display("test half duplex done");
		// point-to-point, odd parity, CR terminator
		md <= 1'b0;
		apb(1'b1, 8'h00, 32'h00100298);
		apb(1'b1, 8'h04, 32'h00000078);
		host_u.par = 1;
		host_u.send_char(8'h0D);
		rchk(8'h08, 32'h0000000D);
		rchk(8'h04, 32'h00000018);
		apb(1'b1, 8'h04, 32'h00000018);
		host_u.par = 2;
		host_u.send_char(8'h31);
		rchk(8'h08, 32'h00000031);
		rchk(8'h04, 32'h00000000);
		host_u.par = 0;
		$display("test odd parity CR done");
		// reset again in mid-run
		RST_N <= 1'b0;
		repeat (2) @(posedge CLK_SYS);
		RST_N <= 1'b1;
		repeat (3) @(posedge CLK_SYS);
		cmp({TXD, TX485, TX485_OE_N}, 3'h7);
		rchk(8'h00, 32'h00000014);
		$display("test second reset done");
		wrap_up();
	end
endmodule // tb_asp_top
